// ---- rtl/pfr_bank.sv ----
// Purpose: Peripheral interrupt flags and power/reset status registers
// Assumes: Classic Wishbone slave; inputs synchronous to I_MCLK
// Notes: Events pulse for one cycle; comparator inputs are levels

// Overview of operation
// R1: NVM write completion sets bit 7, sticky
// R2: Conversion completion sets bit 6, sticky
// R3: Bit 5 mirrors receive-full, read-only
// R4: Comparator B output change sets bit 4
// R5: Comparator A output change sets bit 3
// R6: Oscillator failure sets bit 2, sticky
// R7: Bit 1 mirrors transmit-empty, read-only
// R8: Timer B overflow sets bit 0
// R9: Power bits 7:6, 3:2 read zero
// R10: Bit 5 low-power wake enable, resets zero
// R11: Bit 4 soft brownout enable, resets one
// R12: Power-on reset clears bit 1; software sets
// R13: Brownout reset clears bit 0; software sets
// R14: Flags set regardless of any enable
// R15: Event beats simultaneous software clear
module pfr_bank (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_POR,
  input wire logic I_BOR,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_WE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire pfr_pkg::pfr_evt_s I_EVT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_LOW_POWER_WAKE_ENABLE,
  output logic O_SOFT_BROWNOUT_ENABLE,
  output logic O_IRQ
);

  pfr_pkg::pfr_state_s s_q;
  pfr_pkg::pfr_state_s s_d;

  logic req;
  logic wr;
  logic [3:0] ofs;
  logic [7:0] wbyte;
  logic [7:0] flags_now;
  logic [7:0] events;
  logic [7:0] rd;

  assign req = I_WB_CYC && I_WB_STB && !s_q.ack;
  assign wr = req && I_WB_WE && I_WB_SEL[0];
  assign ofs = I_WB_ADR[3:0];
  assign wbyte = I_WB_DAT[7:0];

  // ---------------------------------------------------------------
  // Combinational next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    events = 8'h00;
    flags_now = s_q.flags;
    rd = 8'h00;

    // Sticky event sources, independent of any enable
    events[pfr_pkg::BIT_NVM_DONE] = I_EVT.nvm_write_done; // R1 R14
    events[pfr_pkg::BIT_CONV_DONE] = I_EVT.conv_done; // R2 R14
    // Compare against previous only once a sample exists
    events[pfr_pkg::BIT_CMP_B] = s_q.cmp_seen && (I_EVT.cmp_b_out != s_q.cmp_b_prev); // R4
    events[pfr_pkg::BIT_CMP_A] = s_q.cmp_seen && (I_EVT.cmp_a_out != s_q.cmp_a_prev); // R5
    events[pfr_pkg::BIT_OSC_FAIL] = I_EVT.osc_fail; // R6
    events[pfr_pkg::BIT_TIMER_B] = I_EVT.timer_b_overflow; // R8
    s_d.cmp_a_prev = I_EVT.cmp_a_out;
    s_d.cmp_b_prev = I_EVT.cmp_b_out;
    s_d.cmp_seen = 1'b1;

    // Software write to sticky bits, then set wins
    if (wr && ofs == pfr_pkg::OFS_FLAGS) begin
      flags_now = (s_q.flags & ~pfr_pkg::FLAGS_SW_MASK) | (wbyte & pfr_pkg::FLAGS_SW_MASK);
    end
    s_d.flags = (flags_now | events) & pfr_pkg::FLAGS_SW_MASK; // R15
    // Live buffer levels, owned by the serial unit
    s_d.flags[pfr_pkg::BIT_RX_FULL] = I_EVT.rx_full; // R3
    s_d.flags[pfr_pkg::BIT_TX_EMPTY] = I_EVT.tx_empty; // R7

    if (wr && ofs == pfr_pkg::OFS_POWER) begin
      s_d.lp_wake = wbyte[pfr_pkg::BIT_LP_WAKE]; // R10
      s_d.soft_bor = wbyte[pfr_pkg::BIT_SOFT_BOR]; // R11
      s_d.por_stat = wbyte[pfr_pkg::BIT_POR_STAT]; // R12
      s_d.bor_stat = wbyte[pfr_pkg::BIT_BOR_STAT]; // R13
    end

    // Interrupt status: set wins over write-one clear
    if (wr && ofs == pfr_pkg::OFS_IRQ_STATUS) begin
      s_d.irq_status = s_q.irq_status & ~wbyte;
    end
    if (wr && ofs == pfr_pkg::OFS_IRQ_ENABLE) begin
      s_d.irq_enable = wbyte;
    end
    s_d.irq_status = s_d.irq_status | events | ({8{1'b0}});
    if (I_EVT.rx_full && !s_q.flags[pfr_pkg::BIT_RX_FULL]) begin
      s_d.irq_status[pfr_pkg::BIT_RX_FULL] = 1'b1;
    end
    if (I_EVT.tx_empty && !s_q.flags[pfr_pkg::BIT_TX_EMPTY]) begin
      s_d.irq_status[pfr_pkg::BIT_TX_EMPTY] = 1'b1;
    end

    // Read mux; unmapped offsets read zero
    unique case (ofs)
      pfr_pkg::OFS_FLAGS: rd = s_q.flags;
      pfr_pkg::OFS_POWER: begin
        rd[pfr_pkg::BIT_LP_WAKE] = s_q.lp_wake;
        rd[pfr_pkg::BIT_SOFT_BOR] = s_q.soft_bor;
        rd[pfr_pkg::BIT_POR_STAT] = s_q.por_stat;
        rd[pfr_pkg::BIT_BOR_STAT] = s_q.bor_stat;
        rd = rd & pfr_pkg::POWER_MASK; // R9
      end
      pfr_pkg::OFS_IRQ_STATUS: rd = s_q.irq_status;
      pfr_pkg::OFS_IRQ_ENABLE: rd = 8'h00;
      default: rd = 8'h00;
    endcase

    s_d.ack = req;
    s_d.rdata = req ? {24'h00_0000, rd} : s_q.rdata;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      s_q <= '0;
      s_q.flags <= pfr_pkg::FLAGS_RST;
      s_q.lp_wake <= pfr_pkg::LP_WAKE_RST; // R10
      s_q.soft_bor <= pfr_pkg::SOFT_BOR_RST; // R11
      s_q.irq_status <= pfr_pkg::IRQ_RST;
      s_q.irq_enable <= pfr_pkg::IRQ_RST;
    end else begin
      s_q <= s_d;
      // Reset cause flags override any software write
      if (I_POR) begin
        s_q.por_stat <= 1'b0; // R12
      end
      if (I_BOR) begin
        s_q.bor_stat <= 1'b0; // R13
      end
    end
  end

  assign O_WB_ACK = s_q.ack;
  assign O_WB_DAT = s_q.rdata;
  assign O_LOW_POWER_WAKE_ENABLE = s_q.lp_wake;
  assign O_SOFT_BROWNOUT_ENABLE = s_q.soft_bor;
  assign O_IRQ = |(s_q.irq_status & s_q.irq_enable);

endmodule

// ---- rtl/pfr_pkg.sv ----
// Purpose: Shared constants and types for the peripheral flag and power control bank
// Assumes: 32-bit classic Wishbone slave, one word per register
// Notes: Byte offsets below are the register addresses

package pfr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_POWER = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'hC;

  // ---------------------------------------------------------------
  // Field positions of the flag register
  // ---------------------------------------------------------------
  localparam int BIT_NVM_DONE = 7;
  localparam int BIT_CONV_DONE = 6;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_CMP_B = 4;
  localparam int BIT_CMP_A = 3;
  localparam int BIT_OSC_FAIL = 2;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_TIMER_B = 0;

  // Bits software may write in the flag register
  localparam logic [7:0] FLAGS_SW_MASK = 8'hDD;

  // ---------------------------------------------------------------
  // Field positions of the power control register
  // ---------------------------------------------------------------
  localparam int BIT_LP_WAKE = 5;
  localparam int BIT_SOFT_BOR = 4;
  localparam int BIT_POR_STAT = 1;
  localparam int BIT_BOR_STAT = 0;
  localparam logic [7:0] POWER_MASK = 8'h33;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic LP_WAKE_RST = 1'b0;
  localparam logic SOFT_BOR_RST = 1'b1;
  localparam logic [7:0] IRQ_RST = 8'h00;

  // ---------------------------------------------------------------
  // Peripheral event inputs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic nvm_write_done;
    logic conv_done;
    logic rx_full;
    logic cmp_b_out;
    logic cmp_a_out;
    logic osc_fail;
    logic tx_empty;
    logic timer_b_overflow;
  } pfr_evt_s;

  // ---------------------------------------------------------------
  // Whole state of the bank
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flags;
    logic lp_wake;
    logic soft_bor;
    logic por_stat;
    logic bor_stat;
    logic cmp_a_prev;
    logic cmp_b_prev;
    logic cmp_seen;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    logic ack;
    logic [31:0] rdata;
  } pfr_state_s;

endpackage

// ---- testbench/pfr_bank_properties.sv ----
// Purpose: Port checks for the flag and power bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module from the bench
module pfr_bank_properties (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_POR,
  input wire logic I_BOR,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_WE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire pfr_pkg::pfr_evt_s I_EVT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_LOW_POWER_WAKE_ENABLE,
  input wire logic O_SOFT_BROWNOUT_ENABLE,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);
  wire tk = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire rp = tk && !I_WB_WE && I_WB_ADR[3:0] == pfr_pkg::OFS_POWER;
  wire wp = tk && I_WB_WE && I_WB_SEL[0] && I_WB_ADR[3:0] == pfr_pkg::OFS_POWER;
  wire rf = tk && !I_WB_WE && I_WB_ADR[3:0] == pfr_pkg::OFS_FLAGS;
  // Only writes at 0x8 or 0xC may lower the interrupt
  wire wi = tk && I_WB_WE && I_WB_ADR[3];
  a_ack_pulse: assert property (tk |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("ack timing");
  a_power_write: assert property (wp |=>
    O_LOW_POWER_WAKE_ENABLE == $past(I_WB_DAT[5]) &&
    O_SOFT_BROWNOUT_ENABLE == $past(I_WB_DAT[4])) else $error("power enables");
  a_power_unused_zero: assert property (rp |=> O_WB_DAT[7:6] == 2'h0 && O_WB_DAT[3:2] == 2'h0)
    else $error("unused power bits");
  a_rx_mirror: assert property (
    rf && $stable(I_EVT.rx_full) |=> O_WB_DAT[5] == $past(I_EVT.rx_full)) else $error("rx bit");
  a_tx_mirror: assert property (
    rf && $stable(I_EVT.tx_empty) |=> O_WB_DAT[1] == $past(I_EVT.tx_empty)) else $error("tx bit");
  a_por_clears: assert property (rp && I_POR && $past(I_POR) |=> !O_WB_DAT[1])
    else $error("por bit");
  a_bor_clears: assert property (rp && I_BOR && $past(I_BOR) |=> !O_WB_DAT[0])
    else $error("bor bit");
  a_irq_sticky: assert property (O_IRQ && !wi |=> O_IRQ)
    else $error("irq dropped");
  c_power: cover property (wp);
  c_irq_read: cover property (rf && O_IRQ);
  c_race: cover property (I_EVT.timer_b_overflow && tk && I_WB_WE);
endmodule

// ---- testbench/pfr_periph_model.sv ----
// Purpose: Peripheral side driving event and level lines
// Assumes: A request shows one edge after it is raised
// Notes: Pulse bits follow requests; comparator lines toggle
module pfr_periph_model (
  input wire logic i_clk,
  input wire logic [7:0] i_fire,
  output pfr_pkg::pfr_evt_s o_evt
);
  initial o_evt = 8'h00;
  // Toggling gives exactly one comparator change per request
  always @(posedge i_clk) o_evt <= {i_fire[7:5], o_evt[4:3] ^ i_fire[4:3], i_fire[2:0]};
endmodule

// ---- testbench/tb_pfr_bank.sv ----
// Purpose: Self-checking bench for the flag and power bank
// Assumes: Master waits for ack, then idles a cycle
// Notes: Expected values come from integer bookkeeping
module tb_pfr_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, por = 0, bor = 0, cyc = 0, we = 0, ack, irq, lpw, sbo;
  logic [3:0] sel = 4'h0;
  logic [31:0] adr = 0, dat = 0, q, rd;
  logic [7:0] fire = 8'h00;
  pfr_pkg::pfr_evt_s evt;
  int failures = 0, n_compared = 0, cnt = 0, r;
  always #10 clk = ~clk;
  pfr_periph_model pfr_periph_model_i (.i_clk(clk), .i_fire(fire), .o_evt(evt));
  pfr_bank pfr_bank_i (.I_MCLK(clk), .I_RESET(rst), .I_POR(por), .I_BOR(bor), .I_WB_ADR(adr),
    .I_WB_DAT(dat), .I_WB_SEL(sel), .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_EVT(evt),
    .O_WB_DAT(q), .O_WB_ACK(ack), .O_LOW_POWER_WAKE_ENABLE(lpw),
    .O_SOFT_BROWNOUT_ENABLE(sbo), .O_IRQ(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    cyc <= 1;
    we <= w;
    adr <= {28'h000_0000, a};
    dat <= {24'h00_0000, d};
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = q;
    cyc <= 0;
    @(posedge clk);
  endtask
  task automatic rst_seq();
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    wb(0, 4'h4, 8'h00, 4'h0);
    chk("power rst", 8'h10, rd);
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cnt++;
    if (cnt > 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    r = $urandom(31);
    rst_seq();
    wb(0, 4'h2, 8'h00, 4'h0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wb(1, 4'h4, r[7:0], 4'h1);
      wb(0, 4'h4, 8'h00, 4'h0);
      chk("power", r[7:0] & 8'h33, rd);
      chk("wake", r[5], lpw);
      chk("sbor", r[4], sbo);
    end
    wb(1, 4'h4, 8'hFF, 4'h0);
    wb(0, 4'h4, 8'h00, 4'h0);
    chk("no sel", r[7:0] & 8'h33, rd);
    wb(1, 4'h4, 8'h33, 4'h1);
    por <= 1;
    @(posedge clk);
    wb(0, 4'h4, 8'h00, 4'h0);
    chk("por", 8'h31, rd);
    por <= 0;
    bor <= 1;
    @(posedge clk);
    wb(0, 4'h4, 8'h00, 4'h0);
    chk("bor", 8'h30, rd);
    bor <= 0;
    wb(1, 4'h4, 8'h03, 4'h1);
    wb(0, 4'h4, 8'h00, 4'h0);
    chk("sw set", 8'h03, rd);
    $display("test power done");
    for (int i = 0; i < 8; i++) begin
      wb(1, 4'hC, (i % 2) ? 8'h00 : 8'hFF, 4'h1);
      fire <= 8'h01 << i;
      @(posedge clk);
      if (i != 5 && i != 1) fire <= 8'h00;
      repeat (3) @(posedge clk);
      wb(0, 4'h0, 8'h00, 4'h0);
      chk("flag", 8'h01 << i, rd);
      chk("irq", i % 2 == 0, irq);
      wb(0, 4'h8, 8'h00, 4'h0);
      chk("status", 8'h01 << i, rd);
      wb(0, 4'hC, 8'h00, 4'h0);
      chk("enable rd", 0, rd);
      fire <= 8'h00;
      wb(1, 4'h0, 8'h00, 4'h1);
      wb(1, 4'h8, 8'hFF, 4'h1);
      wb(0, 4'h0, 8'h00, 4'h0);
      chk("clear", 0, rd);
      chk("irq off", 0, irq);
    end
    $display("test events done");
    fire <= 8'h01;
    @(posedge clk);
    fire <= 8'h00;
    wb(1, 4'h0, 8'h00, 4'h1);
    wb(0, 4'h0, 8'h00, 4'h0);
    chk("race", 8'h01, rd);
    $display("test race done");
    rst_seq();
    $display("test reset done");
    summarize();
  end
endmodule
bind pfr_bank pfr_bank_properties pfr_bank_properties_i (.*);
